/* src/lcd_cfg.svh */
// Register indices, field positions, reset values and limits of the command register set
`ifndef LCD_CFG_SVH
`define LCD_CFG_SVH
// ==========================================================
// Register indices
`define LCD_IDX_CTRL1      8'h00
`define LCD_IDX_CTRL2      8'h01
`define LCD_IDX_RESET      8'h03
`define LCD_IDX_ACCESS     8'h05
`define LCD_IDX_XADDR      8'h06
`define LCD_IDX_YADDR      8'h07
`define LCD_IDX_XMIN       8'h08
`define LCD_IDX_XMAX       8'h09
`define LCD_IDX_YMIN       8'h0a
`define LCD_IDX_YMAX       8'h0b
`define LCD_IDX_MEM        8'h0c
`define LCD_IDX_SCR_START  8'h0f
`define LCD_IDX_SCR_LINES  8'h10
`define LCD_IDX_SCR_STEPS  8'h11
`define LCD_IDX_OFF_COLOUR 8'h13
`define LCD_IDX_P1_START   8'h14
`define LCD_IDX_P2_START   8'h15
`define LCD_IDX_P1_LINES   8'h16
`define LCD_IDX_P2_LINES   8'h17
`define LCD_IDX_PWR1       8'h19
`define LCD_IDX_PWR2       8'h1a
// ==========================================================
// Field positions
`define LCD_C1_PARTIAL 4
`define LCD_C1_LPM     1
`define LCD_C1_GSS     0
`define LCD_C2_PRE     5
`define LCD_C2_GAMMA   4
`define LCD_C2_LTS     1
`define LCD_C2_INV     0
`define LCD_RST_CMD    0
`define LCD_AC_BMD     7
`define LCD_AC_BURST_WRITE_MODE    6
`define LCD_AC_WIN     4
`define LCD_AC_AXIS    2
`define LCD_AC_XDN     1
`define LCD_AC_YDN     0
`define LCD_PW1_VREF   6
`define LCD_PW1_RAIL2  4
`define LCD_PW1_GREG   2
`define LCD_PW1_SREG   1
`define LCD_PW1_BOOST  0
// ==========================================================
// Reset values and limits
`define LCD_REG_RST    8'h00
`define LCD_X_LAST     8'h83
`define LCD_Y_LAST     8'haf
`define LCD_LAST_LINE  8'haf
`define LCD_BURST_LAST 2'h3
`endif

/* src/lcd_pkg.sv */
// Types shared by the command register block and its helpers
package lcd_pkg;
  typedef struct packed {
    logic        cs_n;
    logic        rs;
    logic        wr_n;
    logic        rd_n;
    logic [15:0] data;
  } lcd_host_bus_t;
  typedef struct packed {
    logic        valid;
    logic        burst;
    logic [7:0]  x;
    logic [7:0]  y;
    logic [63:0] data;
  } lcd_ram_wr_t;
  typedef struct packed {
    logic gate_lp;
    logic supply_lp;
    logic gate_reg_en;
    logic supply_reg_en;
    logic boost_en;
    logic boost_hi;
    logic boost_lo;
    logic second_rail;
  } lcd_power_pins_t;
  typedef struct packed {
    logic precharge_gamma;
    logic gamma_internal;
    logic line_period_double;
    logic vcom_ref_ext;
  } lcd_analog_sel_t;
  typedef struct packed {
    logic       win;
    logic       axis;
    logic       xdn;
    logic       ydn;
    logic [7:0] xmin;
    logic [7:0] xmax;
    logic [7:0] ymin;
    logic [7:0] ymax;
  } lcd_addr_cfg_t;
  typedef struct packed {
    logic       partial;
    logic       gss;
    logic       inv_req;
    logic [7:0] ssl;
    logic [7:0] saw;
    logic [7:0] sst;
    logic [7:0] p1s;
    logic [7:0] p1l;
    logic [7:0] p2s;
    logic [7:0] p2l;
    logic [2:0] off_rgb;
  } lcd_scan_cfg_t;
  typedef struct packed {
    logic [7:0] line;
    logic [7:0] src_line;
    logic       gate_en;
    logic       off_area;
    logic [2:0] off_rgb;
    logic       frame_inv;
  } lcd_line_out_t;
  typedef enum logic [0:0] {
    LCD_FILL_EMPTY = 1'b0,
    LCD_FILL_HALF  = 1'b1
  } lcd_fill_t;
endpackage : lcd_pkg

/* src/lcd_addr_counter.sv */
// Display RAM address counter with direction, axis and window wrap
`include "lcd_cfg.svh"
module lcd_addr_counter import lcd_pkg::*; (
  input  wire logic          clk_sys,
  input  wire logic          rst,
  input  wire logic          load_x,
  input  wire logic          load_y,
  input  wire logic [7:0]    load_value,
  input  wire logic          step,
  input  wire lcd_addr_cfg_t cfg,
  output logic [7:0]         x_position,
  output logic [7:0]         y_position
);
  typedef struct packed {
    logic [7:0] x;
    logic [7:0] y;
  } lcd_addr_state_t;

  lcd_addr_state_t st_reg;
  lcd_addr_state_t st_next;

  function automatic logic [7:0] lcd_next_pos(input logic [7:0] pos, input logic down,
                                              input logic win, input logic [7:0] lo,
                                              input logic [7:0] hi, input logic [7:0] last);
    if (!down) begin
      if (win && pos == hi) return lo;
      if (!win && pos == last) return 8'h00;
      return pos + 8'h01;
    end
    if (win && pos == lo) return hi;
    if (!win && pos == 8'h00) return last;
    return pos - 8'h01;
  endfunction : lcd_next_pos

  always_comb begin
    st_next = st_reg;
    if (load_x) st_next.x = load_value;
    if (load_y) st_next.y = load_value;
    if (step && !cfg.axis) begin
      st_next.x = lcd_next_pos(st_reg.x, cfg.xdn, cfg.win, cfg.xmin, cfg.xmax,
                               `LCD_X_LAST);
    end else if (step) begin
      st_next.y = lcd_next_pos(st_reg.y, cfg.ydn, cfg.win, cfg.ymin, cfg.ymax,
                               `LCD_Y_LAST);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) st_reg <= '0;
    else st_reg <= st_next;
  end

  assign x_position = st_reg.x;
  assign y_position = st_reg.y;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_window_x_wrap: assert property (step && cfg.win && !cfg.axis && !cfg.xdn && !load_x &&
    x_position == cfg.xmax |=> x_position == $past(cfg.xmin)) else $error("x window wrap");
  a_axis_y_hold: assert property (step && !cfg.axis && !load_y |=> $stable(y_position))
    else $error("y moved on x step");
  a_y_step_down: assert property (step && cfg.axis && cfg.ydn && !cfg.win && !load_y &&
    y_position != 8'h00 |=> y_position == $past(y_position) - 8'h01)
    else $error("y decrement wrong");
endmodule : lcd_addr_counter

/* src/lcd_line_scan.sv */
// Per-line scroll, partial area, gate scan and inversion state
`include "lcd_cfg.svh"
module lcd_line_scan import lcd_pkg::*; (
  input  wire logic          clk_sys,
  input  wire logic          rst,
  input  wire logic          line_tick,
  input  wire logic          cmd_reset,
  input  wire lcd_scan_cfg_t cfg,
  output lcd_line_out_t      line_out
);
  lcd_line_out_t st_reg;
  lcd_line_out_t st_next;

  always_comb begin
    logic [7:0] ln;
    logic [7:0] ofs;
    logic [7:0] step;
    logic [8:0] sh;
    logic       in1;
    logic       in2;
    ln      = 8'h00;
    ofs     = 8'h00;
    step    = 8'h00;
    sh      = 9'h000;
    in1     = 1'b0;
    in2     = 1'b0;
    st_next = st_reg;
    if (line_tick) begin
      ln = (st_reg.line == `LCD_LAST_LINE) ? 8'h00 : st_reg.line + 8'h01;
      // Inversion change waits for the running scan to finish
      if (st_reg.line == `LCD_LAST_LINE) st_next.frame_inv = cfg.inv_req;
      in1 = (ln >= cfg.p1s) && ((ln - cfg.p1s) < cfg.p1l);
      in2 = (cfg.p1l != 8'h00) && (ln >= cfg.p2s) && ((ln - cfg.p2s) < cfg.p2l);
      st_next.off_area = cfg.partial && !in1 && !in2;
      st_next.gate_en  = !(st_next.off_area && cfg.gss);
      st_next.off_rgb  = cfg.off_rgb;
      step = cfg.partial ? 8'h00 : cfg.sst;
      ofs  = ln - cfg.ssl;
      sh   = {1'b0, ofs} + {1'b0, step};
      // Step counts at or above the band length are not reduced further
      if (sh >= {1'b0, cfg.saw}) sh = sh - {1'b0, cfg.saw};
      if (ln >= cfg.ssl && ofs < cfg.saw) st_next.src_line = cfg.ssl + sh[7:0];
      else st_next.src_line = ln;
      st_next.line = ln;
    end
    if (cmd_reset) st_next.frame_inv = 1'b0;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) st_reg <= '{line: `LCD_LAST_LINE, src_line: 8'h00, gate_en: 1'b1,
                         off_area: 1'b0, off_rgb: 3'h0, frame_inv: 1'b0};
    else st_reg <= st_next;
  end

  assign line_out = st_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_inv_frame_edge: assert property ($changed(line_out.frame_inv) |->
    $past(line_out.line) == `LCD_LAST_LINE || $past(cmd_reset))
    else $error("inversion changed mid scan");
  a_gate_scan_stop: assert property ($past(line_tick) && line_out.off_area |->
    line_out.gate_en == !$past(cfg.gss)) else $error("gate scan stop wrong");
  a_area_two_ignored: assert property ($past(line_tick) && $past(cfg.partial) &&
    $past(cfg.p1l) == 8'h00 |-> line_out.off_area) else $error("area two used");
endmodule : lcd_line_scan

/* src/lcd_cmd_regs.sv */
// Command register set: index-addressed host port, RAM write path, power pins
`include "lcd_cfg.svh"
module lcd_cmd_regs import lcd_pkg::*; (
  input  wire logic          clk_sys,
  input  wire logic          rst,
  input  wire lcd_host_bus_t host_bus,
  input  wire logic          serial_sel,
  input  wire logic          line_tick,
  output logic [15:0]        host_data_out,
  output logic               host_data_oe_n,
  output lcd_ram_wr_t        ram_wr,
  output logic [7:0]         x_position,
  output logic [7:0]         y_position,
  output lcd_line_out_t      line_out,
  output lcd_power_pins_t    power_pins,
  output lcd_analog_sel_t    analog_sel
);
  // ==========================================================
  // State
  typedef struct packed {
    lcd_host_bus_t s1;
    lcd_host_bus_t s2;
    lcd_host_bus_t s3;
    logic [7:0]    index;
    logic [7:0]    ctrl1;
    logic [7:0]    ctrl2;
    logic [7:0]    access;
    logic [7:0]    xmin;
    logic [7:0]    xmax;
    logic [7:0]    ymin;
    logic [7:0]    ymax;
    logic [7:0]    ssl;
    logic [7:0]    saw;
    logic [7:0]    sst;
    logic [7:0]    offc;
    logic [7:0]    p1s;
    logic [7:0]    p2s;
    logic [7:0]    p1l;
    logic [7:0]    p2l;
    logic [7:0]    pwr1;
    logic [7:0]    pwr2;
    lcd_fill_t     fill;
    logic [7:0]    byte_hi;
    logic [1:0]    burst_cnt;
    logic [47:0]   burst_buf;
    lcd_ram_wr_t   ram;
    logic [15:0]   rd_data;
    logic          rd_oe;
    logic          cmd_reset;
  } lcd_top_state_t;

  lcd_top_state_t st_reg;
  lcd_top_state_t st_next;

  logic          wr_evt;
  logic [15:0]   wd;
  logic          byte_mode;
  logic          load_x;
  logic          load_y;
  lcd_addr_cfg_t addr_cfg;
  lcd_scan_cfg_t scan_cfg;

  // ==========================================================
  // Host strobe detection
  // Write is taken on the rising edge of the synchronised write strobe;
  // data comes from the stage captured while the strobe was still low.
  assign wr_evt    = st_reg.s2.wr_n && !st_reg.s3.wr_n && !st_reg.s3.cs_n;
  assign wd        = st_reg.s3.data;
  assign byte_mode = st_reg.access[`LCD_AC_BMD] && !serial_sel;
  assign load_x    = wr_evt && st_reg.s3.rs && st_reg.index == `LCD_IDX_XADDR;
  assign load_y    = wr_evt && st_reg.s3.rs && st_reg.index == `LCD_IDX_YADDR;

  // ==========================================================
  // Next state
  always_comb begin
    logic        word_done;
    logic [15:0] word;
    logic        cmd_soft_reset_now;
    logic [7:0]  rd_mux;
    word_done = 1'b0;
    word      = 16'h0000;
    cmd_soft_reset_now  = 1'b0;
    rd_mux    = 8'h00;
    st_next   = st_reg;
    st_next.s1 = host_bus;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    st_next.ram.valid = 1'b0;
    st_next.cmd_reset = 1'b0;

    if (wr_evt && !st_reg.s3.rs) st_next.index = wd[7:0];
    if (wr_evt && st_reg.s3.rs) begin
      case (st_reg.index)
        `LCD_IDX_CTRL1:      st_next.ctrl1 = wd[7:0];
        `LCD_IDX_CTRL2:      st_next.ctrl2 = wd[7:0];
        `LCD_IDX_RESET:      cmd_soft_reset_now = wd[`LCD_RST_CMD];
        `LCD_IDX_ACCESS: begin
          st_next.access    = wd[7:0];
          // A width or mode change drops any half-built unit
          st_next.fill      = LCD_FILL_EMPTY;
          st_next.burst_cnt = 2'h0;
        end
        `LCD_IDX_XMIN:       st_next.xmin = wd[7:0];
        `LCD_IDX_XMAX:       st_next.xmax = wd[7:0];
        `LCD_IDX_YMIN:       st_next.ymin = wd[7:0];
        `LCD_IDX_YMAX:       st_next.ymax = wd[7:0];
        `LCD_IDX_SCR_START:  st_next.ssl = wd[7:0];
        `LCD_IDX_SCR_LINES:  st_next.saw = wd[7:0];
        `LCD_IDX_SCR_STEPS:  st_next.sst = wd[7:0];
        `LCD_IDX_OFF_COLOUR: st_next.offc = {5'h00, wd[2:0]};
        `LCD_IDX_P1_START:   st_next.p1s = wd[7:0];
        `LCD_IDX_P2_START:   st_next.p2s = wd[7:0];
        `LCD_IDX_P1_LINES:   st_next.p1l = wd[7:0];
        `LCD_IDX_P2_LINES:   st_next.p2l = wd[7:0];
        `LCD_IDX_PWR1:       st_next.pwr1 = wd[7:0];
        `LCD_IDX_PWR2:       st_next.pwr2 = {6'h00, wd[1:0]};
        `LCD_IDX_MEM: begin
          if (byte_mode && st_reg.fill == LCD_FILL_EMPTY) begin
            st_next.byte_hi = wd[7:0];
            st_next.fill    = LCD_FILL_HALF;
          end else if (byte_mode) begin
            word         = {st_reg.byte_hi, wd[7:0]};
            word_done    = 1'b1;
            st_next.fill = LCD_FILL_EMPTY;
          end else begin
            word      = wd;
            word_done = 1'b1;
          end
        end
        default: ;
      endcase
    end

    // RAM commit: burst gathers four words before one 64-bit write
    if (word_done && st_reg.access[`LCD_AC_BURST_WRITE_MODE]) begin
      if (st_reg.burst_cnt == `LCD_BURST_LAST) begin
        st_next.ram.data  = {st_reg.burst_buf, word};
        st_next.ram.valid = 1'b1;
        st_next.ram.burst = 1'b1;
        st_next.burst_cnt = 2'h0;
      end else begin
        st_next.burst_buf = {st_reg.burst_buf[31:0], word};
        st_next.burst_cnt = st_reg.burst_cnt + 2'h1;
      end
    end else if (word_done) begin
      st_next.ram.data  = {48'h0, word};
      st_next.ram.valid = 1'b1;
      st_next.ram.burst = 1'b0;
    end
    if (st_next.ram.valid) begin
      st_next.ram.x = x_position;
      st_next.ram.y = y_position;
    end

    // Self-clearing command reset: nothing is held, so the next write
    // may follow straight away
    if (cmd_soft_reset_now) begin
      st_next.ctrl1     = `LCD_REG_RST;
      st_next.ctrl2     = `LCD_REG_RST;
      st_next.access    = `LCD_REG_RST;
      st_next.fill      = LCD_FILL_EMPTY;
      st_next.burst_cnt = 2'h0;
      st_next.cmd_reset = 1'b1;
    end

    // Read path; write-only and unused indices read as zero
    case (st_reg.index)
      `LCD_IDX_CTRL1:      rd_mux = st_reg.ctrl1;
      `LCD_IDX_CTRL2:      rd_mux = st_reg.ctrl2;
      `LCD_IDX_ACCESS:     rd_mux = st_reg.access;
      `LCD_IDX_XADDR:      rd_mux = x_position;
      `LCD_IDX_YADDR:      rd_mux = y_position;
      `LCD_IDX_XMIN:       rd_mux = st_reg.xmin;
      `LCD_IDX_XMAX:       rd_mux = st_reg.xmax;
      `LCD_IDX_YMIN:       rd_mux = st_reg.ymin;
      `LCD_IDX_YMAX:       rd_mux = st_reg.ymax;
      `LCD_IDX_SCR_START:  rd_mux = st_reg.ssl;
      `LCD_IDX_SCR_LINES:  rd_mux = st_reg.saw;
      `LCD_IDX_SCR_STEPS:  rd_mux = st_reg.sst;
      `LCD_IDX_OFF_COLOUR: rd_mux = st_reg.offc;
      `LCD_IDX_P1_START:   rd_mux = st_reg.p1s;
      `LCD_IDX_P2_START:   rd_mux = st_reg.p2s;
      `LCD_IDX_P1_LINES:   rd_mux = st_reg.p1l;
      `LCD_IDX_P2_LINES:   rd_mux = st_reg.p2l;
      `LCD_IDX_PWR1:       rd_mux = st_reg.pwr1;
      `LCD_IDX_PWR2:       rd_mux = st_reg.pwr2;
      default:             rd_mux = 8'h00;
    endcase
    st_next.rd_oe   = !st_reg.s2.cs_n && !st_reg.s2.rd_n && st_reg.s2.rs;
    st_next.rd_data = {8'h00, rd_mux};
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_reg         <= '0;
      st_reg.s1      <= '{cs_n: 1'b1, rs: 1'b0, wr_n: 1'b1, rd_n: 1'b1, data: 16'h0000};
      st_reg.s2      <= '{cs_n: 1'b1, rs: 1'b0, wr_n: 1'b1, rd_n: 1'b1, data: 16'h0000};
      st_reg.s3      <= '{cs_n: 1'b1, rs: 1'b0, wr_n: 1'b1, rd_n: 1'b1, data: 16'h0000};
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Helpers
  assign addr_cfg = '{win: st_reg.access[`LCD_AC_WIN], axis: st_reg.access[`LCD_AC_AXIS],
                      xdn: st_reg.access[`LCD_AC_XDN], ydn: st_reg.access[`LCD_AC_YDN],
                      xmin: st_reg.xmin, xmax: st_reg.xmax,
                      ymin: st_reg.ymin, ymax: st_reg.ymax};

  lcd_addr_counter u_addr (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .load_x     (load_x),
    .load_y     (load_y),
    .load_value (wd[7:0]),
    .step       (st_next.ram.valid),
    .cfg        (addr_cfg),
    .x_position (x_position),
    .y_position (y_position)
  );

  assign scan_cfg = '{partial: st_reg.ctrl1[`LCD_C1_PARTIAL], gss: st_reg.ctrl1[`LCD_C1_GSS],
                      inv_req: st_reg.ctrl2[`LCD_C2_INV],
                      ssl: st_reg.ssl, saw: st_reg.saw, sst: st_reg.sst,
                      p1s: st_reg.p1s, p1l: st_reg.p1l, p2s: st_reg.p2s, p2l: st_reg.p2l,
                      off_rgb: st_reg.offc[2:0]};

  lcd_line_scan u_scan (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .line_tick (line_tick),
    .cmd_reset (st_reg.cmd_reset),
    .cfg       (scan_cfg),
    .line_out  (line_out)
  );

  // ==========================================================
  // Outputs
  assign host_data_out  = st_reg.rd_data;
  assign host_data_oe_n = !st_reg.rd_oe;
  assign ram_wr         = st_reg.ram;

  assign power_pins.gate_lp       = st_reg.ctrl1[`LCD_C1_LPM];
  assign power_pins.supply_lp     = st_reg.ctrl1[`LCD_C1_LPM];
  assign power_pins.gate_reg_en   = st_reg.pwr1[`LCD_PW1_GREG];
  assign power_pins.supply_reg_en = st_reg.pwr1[`LCD_PW1_SREG];
  assign power_pins.boost_en      = st_reg.pwr1[`LCD_PW1_BOOST];
  assign power_pins.boost_hi      = st_reg.pwr2[1];
  assign power_pins.boost_lo      = st_reg.pwr2[0];
  assign power_pins.second_rail   = st_reg.pwr1[`LCD_PW1_RAIL2];

  assign analog_sel.precharge_gamma    = st_reg.ctrl2[`LCD_C2_PRE];
  assign analog_sel.gamma_internal     = st_reg.ctrl2[`LCD_C2_GAMMA];
  assign analog_sel.line_period_double = st_reg.ctrl2[`LCD_C2_LTS];
  assign analog_sel.vcom_ref_ext       = st_reg.pwr1[`LCD_PW1_VREF];

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_data_write(logic [7:0] idx);
    wr_evt && st_reg.s3.rs && st_reg.index == idx;
  endsequence

  a_low_power_pins: assert property (s_data_write(`LCD_IDX_CTRL1) ##0 wd[`LCD_C1_LPM] |=>
    power_pins.gate_lp && power_pins.supply_lp) else $error("low power pins not high");
  a_cmd_soft_reset_self_clear: assert property (s_data_write(`LCD_IDX_RESET) ##0 wd[`LCD_RST_CMD] |=>
    st_reg.cmd_reset && st_reg.ctrl2 == `LCD_REG_RST ##1 !st_reg.cmd_reset)
    else $error("command reset not self clearing");
  a_byte_pairing: assert property (ram_wr.valid && !ram_wr.burst && $past(byte_mode) |->
    $past(st_reg.fill) == LCD_FILL_HALF) else $error("byte write without pair");
  a_burst_commit: assert property (ram_wr.valid && ram_wr.burst |->
    $past(st_reg.burst_cnt) == `LCD_BURST_LAST) else $error("burst commit early");
  a_boost_ratio: assert property (s_data_write(`LCD_IDX_PWR2) ##0 wd[1] && !wd[0] |=>
    power_pins.boost_hi && !power_pins.boost_lo) else $error("boost ratio pins wrong");

  // ==========================================================
  // Memory port checks
  sequence s_mem_word;
    s_data_write(`LCD_IDX_MEM) ##0 (!byte_mode || st_reg.fill == LCD_FILL_HALF);
  endsequence

  // Outside burst mode each finished word must land on the next cycle, at the address before the step
  a_single_commit: assert property (s_mem_word ##0 !st_reg.access[`LCD_AC_BURST_WRITE_MODE] |=>
    ram_wr.valid && !ram_wr.burst)
    else $error("word not committed");
  a_burst_gather: assert property (s_mem_word ##0 st_reg.access[`LCD_AC_BURST_WRITE_MODE] &&
    st_reg.burst_cnt != `LCD_BURST_LAST |=> !ram_wr.valid)
    else $error("burst committed early");
  a_byte_half_hold: assert property (s_data_write(`LCD_IDX_MEM) ##0 byte_mode &&
    st_reg.fill == LCD_FILL_EMPTY |=> !ram_wr.valid && st_reg.fill == LCD_FILL_HALF)
    else $error("half word committed");
  a_commit_address: assert property (ram_wr.valid |->
    ram_wr.x == $past(x_position) && ram_wr.y == $past(y_position))
    else $error("commit address wrong");
  a_x_load: assert property (load_x |=> x_position == $past(wd[7:0]))
    else $error("x address not loaded");
  a_cmd_soft_reset_drops_unit: assert property (s_data_write(`LCD_IDX_RESET) ##0 wd[`LCD_RST_CMD] |=>
    st_reg.fill == LCD_FILL_EMPTY && st_reg.burst_cnt == 2'h0 && st_reg.access == `LCD_REG_RST)
    else $error("command reset kept assembly");
  a_index_write: assert property (wr_evt && !st_reg.s3.rs |=>
    st_reg.index == $past(wd[7:0]))
    else $error("index not written");
  a_pwr_write: assert property (s_data_write(`LCD_IDX_PWR1) |=>
    power_pins.boost_en == $past(wd[`LCD_PW1_BOOST]) && power_pins.gate_reg_en == $past(wd[`LCD_PW1_GREG]))
    else $error("power enable pins wrong");
  a_ctrl2_write: assert property (s_data_write(`LCD_IDX_CTRL2) |=>
    analog_sel.precharge_gamma == $past(wd[`LCD_C2_PRE]) && analog_sel.gamma_internal == $past(wd[`LCD_C2_GAMMA]))
    else $error("analog selects wrong");
  a_read_upper_zero: assert property (!host_data_oe_n |-> host_data_out[15:8] == 8'h00)
    else $error("read upper byte not zero");
endmodule : lcd_cmd_regs

/* tb/lcd_host_model.sv */
// Host processor model driving the index-addressed command port
module lcd_host_model import lcd_pkg::*; (
  output lcd_host_bus_t host_bus,
  input  wire logic     clk_sys
);
  timeunit 1ns;
  timeprecision 1ps;
  initial host_bus = '{cs_n: 1'b1, rs: 1'b0, wr_n: 1'b1, rd_n: 1'b1, data: 16'h0000};
  // ====
  // Strobe phases span more cycles than the pin synchroniser needs
  task automatic put(input logic rs, input logic [15:0] d);
    @(posedge clk_sys);
    host_bus.cs_n <= 1'b0;
    host_bus.rs   <= rs;
    host_bus.data <= d;
    host_bus.wr_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    host_bus.wr_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    // Released lines show the inverse, never a stale value
    host_bus.data <= ~d;
  endtask : put
  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    put(1'b0, {8'h00, idx});
    put(1'b1, d);
  endtask : wr
endmodule : lcd_host_model

/* tb/lcd_cmd_regs_tb.sv */
// Self-checking bench for the command register block
`include "lcd_cfg.svh"
module lcd_cmd_regs_tb import lcd_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic            clk_sys = 1'b0;
  logic            rst = 1'b1;
  lcd_host_bus_t   host_bus;
  lcd_ram_wr_t     ram_wr;
  lcd_power_pins_t power_pins;
  lcd_analog_sel_t analog_sel;
  lcd_line_out_t   line_out;
  logic [15:0]     host_data_out;
  logic            host_data_oe_n;
  logic [7:0]      x_position;
  logic [7:0]      y_position;
  logic            line_tick = 1'b0;
  logic            serial_sel = 1'b0;
  int              n_errors = 0;
  int              total_checks = 0;
  logic [80:0]     exp_q[$];
  logic [31:0]     seed = 32'h9363;
  always #5 clk_sys = ~clk_sys;
  lcd_host_model u_lcd_host_model (.host_bus(host_bus), .clk_sys(clk_sys));
  lcd_cmd_regs u_lcd_cmd_regs (.clk_sys(clk_sys), .rst(rst), .host_bus(host_bus),
    .serial_sel(serial_sel), .line_tick(line_tick), .host_data_out(host_data_out),
    .host_data_oe_n(host_data_oe_n), .ram_wr(ram_wr), .x_position(x_position),
    .y_position(y_position), .line_out(line_out), .power_pins(power_pins),
    .analog_sel(analog_sel));
  // ====
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic check(input logic [80:0] seen, input logic [80:0] want);
    total_checks++;
    if (seen !== want) begin
      n_errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  task automatic setup(input logic [7:0] ac, input logic [7:0] x, input logic [7:0] y);
    u_lcd_host_model.wr(`LCD_IDX_ACCESS, {8'h00, ac});
    u_lcd_host_model.wr(`LCD_IDX_XADDR, {8'h00, x});
    u_lcd_host_model.wr(`LCD_IDX_YADDR, {8'h00, y});
  endtask : setup
  task automatic word(input logic [7:0] x, input logic [7:0] y);
    seed = xs(seed);
    exp_q.push_back({1'b0, x, y, 48'h0, seed[15:0]});
    u_lcd_host_model.wr(`LCD_IDX_MEM, seed[15:0]);
  endtask : word
  task automatic tick;
    @(posedge clk_sys);
    line_tick <= 1'b1;
    @(posedge clk_sys);
    line_tick <= 1'b0;
    @(posedge clk_sys);
  endtask : tick
  // ====
  // Commit watcher
  always @(posedge clk_sys) begin
    if (ram_wr.valid === 1'b1) begin
      if (exp_q.size() == 0) check(81'h1, 81'h0);
      else check({ram_wr.burst, ram_wr.x, ram_wr.y, ram_wr.data}, exp_q.pop_front());
    end
  end
  initial begin
    #100000;
    n_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    wrap_up();
  end
  // ====
  // Tests
  initial begin
    logic [63:0] b;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    u_lcd_host_model.wr(`LCD_IDX_RESET, 16'h0001);
    // No wait after the reset command
    u_lcd_host_model.wr(`LCD_IDX_CTRL1, 16'h0002);
    check({power_pins.gate_lp, power_pins.supply_lp}, 2'h3);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      u_lcd_host_model.wr(`LCD_IDX_PWR1, {8'h00, seed[7:0]});
      u_lcd_host_model.wr(`LCD_IDX_PWR2, 16'(i));
      check({power_pins.gate_reg_en, power_pins.supply_reg_en, power_pins.boost_en,
             power_pins.boost_hi, power_pins.boost_lo, power_pins.second_rail,
             analog_sel.vcom_ref_ext}, {seed[2:0], 2'(i), seed[4], seed[6]});
    end
    u_lcd_host_model.wr(`LCD_IDX_CTRL2, {8'h00, seed[15:8]});
    check({analog_sel.precharge_gamma, analog_sel.gamma_internal,
           analog_sel.line_period_double}, {seed[13], seed[12], seed[9]});
    u_lcd_host_model.wr(`LCD_IDX_RESET, 16'h0001);
    check({power_pins.gate_lp, power_pins.supply_lp, analog_sel[3:1]}, 5'h0);
    $display("test control bits done");
    setup(8'h00, 8'h83, 8'h05);
    word(8'h83, 8'h05);
    word(8'h00, 8'h05);
    u_lcd_host_model.wr(`LCD_IDX_XMIN, 16'h0002);
    u_lcd_host_model.wr(`LCD_IDX_XMAX, 16'h0004);
    setup(8'h10, 8'h03, 8'h07);
    for (int i = 0; i < 3; i++) word(8'(2 + (i + 1) % 3), 8'h07);
    setup(8'h05, 8'h20, 8'h10);
    word(8'h20, 8'h10);
    word(8'h20, 8'h0f);
    setup(8'h80, 8'h00, 8'h00);
    seed = xs(seed);
    exp_q.push_back({1'b0, 16'h0000, 48'h0, seed[15:0]});
    u_lcd_host_model.wr(`LCD_IDX_MEM, {8'h00, seed[15:8]});
    u_lcd_host_model.wr(`LCD_IDX_MEM, {8'h00, seed[7:0]});
    // Serial link ignores the width bit: whole words commit at once
    serial_sel <= 1'b1;
    word(8'h01, 8'h00);
    serial_sel <= 1'b0;
    setup(8'h40, 8'h10, 8'h20);
    seed = xs(seed);
    b[63:32] = seed;
    seed = xs(seed);
    b[31:0] = seed;
    exp_q.push_back({1'b1, 8'h10, 8'h20, b});
    for (int i = 0; i < 4; i++) u_lcd_host_model.wr(`LCD_IDX_MEM, b[63 - 16 * i -: 16]);
    repeat (20) @(posedge clk_sys);
    check(exp_q.size(), 0);
    $display("test address counter done");
    u_lcd_host_model.wr(`LCD_IDX_P1_START, 16'h0002);
    u_lcd_host_model.wr(`LCD_IDX_P1_LINES, 16'h0003);
    u_lcd_host_model.wr(`LCD_IDX_P2_START, 16'h000a);
    u_lcd_host_model.wr(`LCD_IDX_P2_LINES, 16'h0002);
    u_lcd_host_model.wr(`LCD_IDX_OFF_COLOUR, 16'h0005);
    u_lcd_host_model.wr(`LCD_IDX_CTRL1, 16'h0011);
    for (int i = 0; i < 176; i++) begin
      tick();
      if (i == 0) u_lcd_host_model.wr(`LCD_IDX_CTRL2, 16'h0001);
      check({line_out.line, line_out.off_area, line_out.gate_en, line_out.off_rgb,
             line_out.frame_inv}, {8'(i), !((i >= 2 && i < 5) || (i >= 10 && i < 12)),
             (i >= 2 && i < 5) || (i >= 10 && i < 12), 3'h5, 1'b0});
    end
    tick();
    check({line_out.line, line_out.frame_inv}, {8'h00, 1'b1});
    u_lcd_host_model.wr(`LCD_IDX_RESET, 16'h0001);
    check(line_out.frame_inv, 1'b0);
    u_lcd_host_model.wr(`LCD_IDX_SCR_START, 16'h0002);
    u_lcd_host_model.wr(`LCD_IDX_SCR_LINES, 16'h0004);
    u_lcd_host_model.wr(`LCD_IDX_SCR_STEPS, 16'h0001);
    u_lcd_host_model.wr(`LCD_IDX_P2_START, 16'h0001);
    u_lcd_host_model.wr(`LCD_IDX_P1_LINES, 16'h0000);
    u_lcd_host_model.wr(`LCD_IDX_CTRL1, 16'h0010);
    for (int i = 1; i < 10; i++) begin
      if (i == 4) u_lcd_host_model.wr(`LCD_IDX_CTRL1, 16'h0000);
      tick();
      check({line_out.src_line, line_out.off_area}, (i < 4) ? {8'(i), 1'b1} :
            (i < 6) ? {8'(2 + (i - 1) % 4), 1'b0} : {8'(i), 1'b0});
    end
    $display("test line scan done");
    wrap_up();
  end
endmodule : lcd_cmd_regs_tb
